// *** rtl/vepix_pkg.sv ***
// Purpose: Shared constants and types of the video encoder pixel port.
// Assumes: 32-bit AHB-Lite register bus, one word per register.
// Notes: Line and field sizes are plain defaults, overridable.
package vepix_pkg;
    // Register byte offsets
    localparam logic [7:0] VEPIX_MODE_ADDR = 8'h00;
    localparam logic [7:0] VEPIX_TIMING_ADDR = 8'h04;
    localparam logic [7:0] VEPIX_MODE3_ADDR = 8'h08;
    localparam logic [7:0] VEPIX_STATUS_ADDR = 8'h0C;
    localparam logic [7:0] VEPIX_OVL_BASE = 8'h40;
    localparam logic [7:0] VEPIX_OVL_LAST = 8'h5C;
    // Field positions
    localparam int VEPIX_STD_BIT = 0;
    localparam int VEPIX_OUTSEL_LSB = 1;
    localparam int VEPIX_MASTER_BIT = 0;
    localparam int VEPIX_TMODE_LSB = 1;
    localparam int VEPIX_WIDE_BIT = 0;
    localparam int VEPIX_CLKA_BIT = 2;
    localparam int VEPIX_CLKB_BIT = 3;
    localparam int VEPIX_FIELD_BIT = 16;
    localparam int VEPIX_ADDRSEL_BIT = 17;
    localparam int VEPIX_HIT_BIT = 18;
    // Reset values: NTSC, slave mode 0, 8-bit, composite plus S-video
    localparam logic VEPIX_STD_RST = 1'b0;
    localparam logic [1:0] VEPIX_OUTSEL_RST = 2'h0;
    localparam logic VEPIX_MASTER_RST = 1'b0;
    localparam logic [1:0] VEPIX_TMODE_RST = 2'h0;
    localparam logic VEPIX_WIDE_RST = 1'b0;
    localparam logic [1:0] VEPIX_CLKSEL_RST = 2'h0;
    localparam logic [1:0] VEPIX_TMODE_VSYNC = 2'h2;
    // Serial control port device address, upper six bits; value arbitrary
    localparam logic [5:0] VEPIX_SER_ADDR_HI = 6'h2A;
    // AHB encodings
    localparam logic [1:0] VEPIX_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] VEPIX_HSIZE_WORD = 3'h2;
    // Byte order in 8-bit mode: Cb, Y, Cr, Y
    localparam logic [1:0] VEPIX_PH_CB = 2'h0;
    localparam logic [1:0] VEPIX_PH_CR = 2'h2;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } vepix_pixel_s;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } vepix_ahb_req_s;

    typedef enum logic [1:0] {
        VEPIX_SER_IDLE = 2'b00,
        VEPIX_SER_ADDR = 2'b01,
        VEPIX_SER_ACK = 2'b11,
        VEPIX_SER_DONE = 2'b10
    } vepix_ser_e;
endpackage : vepix_pkg

// *** rtl/vepix_port.sv ***
// Purpose: Pixel input port, timing pins, overlay and clock output.
// Assumes: One 100 MHz clock; pins pass two flip-flops before use.
// Notes: Registers over AHB-Lite, zero wait states, always OKAY.
// What this block does
// (RULE_01) Clock output runs at full or half rate, set by two mode bits.
// (RULE_02) Pixels come as 8 bits on the low byte or 16 bits, bit 0 LSB.
// (RULE_03) While overlay is enabled its colour replaces the video.
// (RULE_04) Hsync pin is driven as master and received as slave.
// (RULE_05) Field pin is a field flag in mode 1, vsync in mode 2.
// (RULE_06) Pixel data is ignored while blanking is low.
// (RULE_07) Serial address LSB comes from the address-select pin.
// (RULE_08) Reset restarts timing and loads NTSC, slave 0, 8-bit defaults.
// (RULE_09) The clock source supplies a stable pixel-rate reference.
// (RULE_10) Serial clock is input only; serial data is two-way.
// (RULE_11) In 8-bit mode bytes come Cb, Y, Cr, Y on rising edges.
// (RULE_12) In 16-bit mode Y is low, chroma high, taken every 2nd edge.
// (RULE_13) As slave the line and field counters follow received syncs.
// (RULE_14) Three select inputs pick one of eight overlay colours.
`timescale 1ns/1ps
module vepix_port #(
    parameter int LINE_CLKS = 1716,
    parameter int FIELD_LINES = 263,
    parameter int HSYNC_CLKS = 128,
    parameter int VSYNC_LINES = 3
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    // AHB-Lite slave
    input wire vepix_pkg::vepix_ahb_req_s ahb_req_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Pixel port and timing pins
    input wire logic [15:0] pixel_bus_in,
    input wire logic blank_in,
    input wire logic hsync_in,
    output logic hsync_out,
    output logic hsync_oe_n_out,
    input wire logic field_vsync_in,
    output logic field_vsync_out,
    output logic field_vsync_oe_n_out,
    // Overlay pins
    input wire logic overlay_enable_in,
    input wire logic [2:0] overlay_color_select_in,
    // Serial control port and address select
    input wire logic address_select_pin_in,
    input wire logic control_serial_clock_in,
    input wire logic control_serial_data_in,
    output logic control_serial_data_out,
    output logic control_serial_data_oe_n_out,
    // Video out and divided clock
    output vepix_pkg::vepix_pixel_s pixel_out,
    output logic pixel_valid_out,
    output logic clock_div_out
);
    import vepix_pkg::*;

    // Two-stage synchronisers for every pin input
    localparam int NSYNC = 26;
    logic [NSYNC-1:0] pin_raw, pin_s1, pin_s2;
    assign pin_raw = {pixel_bus_in, blank_in, hsync_in, field_vsync_in,
                      overlay_enable_in, overlay_color_select_in,
                      address_select_pin_in, control_serial_clock_in,
                      control_serial_data_in};
    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end
    logic [15:0] pix_s;
    logic blank_s, hs_s, fv_s, ovl_s, addr_sel_s, scl_s, sda_s;
    logic [2:0] osel_s;
    assign {pix_s, blank_s, hs_s, fv_s, ovl_s, osel_s, addr_sel_s, scl_s,
            sda_s} = pin_s2;

    // Control registers
    logic std_pal, master, wide;
    logic [1:0] outsel, tmode, clksel;
    logic [11:0] ovl_tbl [8];
    logic ser_hit;

    // AHB-Lite: address phase captured, write done in data phase
    logic wr_pend;
    logic [7:0] wr_addr;
    wire acc = ahb_req_in.hsel && ahb_req_in.hready
               && ahb_req_in.htrans == VEPIX_HTRANS_NONSEQ;
    wire [7:0] a8 = ahb_req_in.haddr[7:0];
    wire in_tbl_w = wr_addr >= VEPIX_OVL_BASE && wr_addr <= VEPIX_OVL_LAST;
    wire in_tbl_r = a8 >= VEPIX_OVL_BASE && a8 <= VEPIX_OVL_LAST;
    wire [2:0] tbl_idx_w = 3'(wr_addr[4:2]);
    wire [2:0] tbl_idx_r = 3'(a8[4:2]);
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    // Timing generator counters
    logic [11:0] h_cnt;
    logic [9:0] v_cnt;
    logic field;

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (a8)
            VEPIX_MODE_ADDR: begin
                next_rdata[VEPIX_STD_BIT] = std_pal;
                next_rdata[VEPIX_OUTSEL_LSB +: 2] = outsel;
            end
            VEPIX_TIMING_ADDR: begin
                next_rdata[VEPIX_MASTER_BIT] = master;
                next_rdata[VEPIX_TMODE_LSB +: 2] = tmode;
            end
            VEPIX_MODE3_ADDR: begin
                next_rdata[VEPIX_WIDE_BIT] = wide;
                next_rdata[VEPIX_CLKA_BIT] = clksel[0];
                next_rdata[VEPIX_CLKB_BIT] = clksel[1];
            end
            VEPIX_STATUS_ADDR: begin
                next_rdata[9:0] = v_cnt;
                next_rdata[VEPIX_FIELD_BIT] = field;
                next_rdata[VEPIX_ADDRSEL_BIT] = addr_sel_s;
                next_rdata[VEPIX_HIT_BIT] = ser_hit;
            end
            default: begin
                if (in_tbl_r) begin
                    next_rdata[11:0] = ovl_tbl[tbl_idx_r];
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata_out <= 32'h0000_0000;
        end else if (ce_in) begin
            wr_pend <= acc && ahb_req_in.hwrite;
            wr_addr <= a8;
            if (acc && !ahb_req_in.hwrite) begin
                hrdata_out <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            std_pal <= VEPIX_STD_RST; // RULE_08
            outsel <= VEPIX_OUTSEL_RST; // RULE_08
            master <= VEPIX_MASTER_RST; // RULE_08
            tmode <= VEPIX_TMODE_RST; // RULE_08
            wide <= VEPIX_WIDE_RST; // RULE_08
            clksel <= VEPIX_CLKSEL_RST;
        end else if (ce_in && wr_pend) begin
            if (wr_addr == VEPIX_MODE_ADDR) begin
                std_pal <= hwdata_in[VEPIX_STD_BIT];
                outsel <= hwdata_in[VEPIX_OUTSEL_LSB +: 2];
            end
            if (wr_addr == VEPIX_TIMING_ADDR) begin
                master <= hwdata_in[VEPIX_MASTER_BIT];
                tmode <= hwdata_in[VEPIX_TMODE_LSB +: 2];
            end
            if (wr_addr == VEPIX_MODE3_ADDR) begin
                wide <= hwdata_in[VEPIX_WIDE_BIT];
                clksel <= {hwdata_in[VEPIX_CLKB_BIT],
                           hwdata_in[VEPIX_CLKA_BIT]}; // RULE_01
            end
        end
    end

    // Colour table has no reset; software loads it before overlay use
    always_ff @(posedge clk_in) begin
        if (ce_in && wr_pend && in_tbl_w) begin
            ovl_tbl[tbl_idx_w] <= hwdata_in[11:0];
        end
    end

    // Clock output: bit b enables, bit a picks half rate
    logic div_ff;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            div_ff <= 1'b0;
        end else if (ce_in) begin
            div_ff <= ~div_ff;
        end
    end
    assign clock_div_out = clksel[1]
                         & (clksel[0] ? div_ff : clk_in); // RULE_01

    // Timing generator; slave edges realign counters
    logic hs_d, fv_d;
    wire hs_fall = hs_d && !hs_s;
    wire fv_fall = fv_d && !fv_s;
    wire fv_chg = fv_d != fv_s;
    // Compare with >= so a count left over from slave mode wraps at once
    wire line_end = master ? (h_cnt >= 12'(LINE_CLKS - 1)) : hs_fall;
    wire field_end = master ? (v_cnt >= 10'(FIELD_LINES - 1))
                   : (tmode == VEPIX_TMODE_VSYNC ? fv_fall : fv_chg);
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            h_cnt <= 12'h000; // RULE_08
            v_cnt <= 10'h000; // RULE_08
            field <= 1'b0;
            hs_d <= 1'b1;
            // Start from the pin level: the field pin has no idle level
            fv_d <= fv_s;
        end else if (ce_in) begin
            hs_d <= hs_s;
            fv_d <= fv_s;
            if (line_end) begin
                h_cnt <= 12'h000; // RULE_13
                if (field_end && master) begin
                    v_cnt <= 10'h000;
                    field <= ~field;
                end else begin
                    v_cnt <= v_cnt + 10'h001;
                end
            end else begin
                h_cnt <= h_cnt + 12'h001;
            end
            if (!master && field_end) begin
                v_cnt <= 10'h000; // RULE_13
                field <= (tmode == VEPIX_TMODE_VSYNC) ? ~field : fv_s;
            end
        end
    end
    // Sync pins active low; released in slave modes
    assign hsync_oe_n_out = !master; // RULE_04
    assign field_vsync_oe_n_out = !master; // RULE_05
    assign hsync_out = !(h_cnt < 12'(HSYNC_CLKS)); // RULE_04
    assign field_vsync_out = (tmode == VEPIX_TMODE_VSYNC)
                           ? !(v_cnt < 10'(VSYNC_LINES)) : field; // RULE_05

    // Pixel capture
    logic [1:0] phase;
    logic cr_turn;
    logic [7:0] cb_r, cr_r;
    wire take = blank_s; // RULE_06
    wire [7:0] lo = pix_s[7:0]; // RULE_02
    wire [7:0] hi = pix_s[15:8]; // RULE_02
    wire cap8 = take && !wide && phase[0]; // RULE_11
    wire cap16 = take && wide && !phase[0]; // RULE_12
    wire [11:0] ovl_col = ovl_tbl[osel_s]; // RULE_14
    vepix_pixel_s cap_pix, next_pix;
    always_comb begin
        cap_pix.y = lo;
        cap_pix.cb = cb_r;
        cap_pix.cr = cr_r;
        if (wide) begin
            if (cr_turn) begin
                cap_pix.cr = hi; // RULE_12
            end else begin
                cap_pix.cb = hi; // RULE_12
            end
        end
        next_pix = cap_pix;
        if (ovl_s) begin
            next_pix.y = {ovl_col[11:8], 4'h0}; // RULE_03
            next_pix.cb = {ovl_col[7:4], 4'h0}; // RULE_03
            next_pix.cr = {ovl_col[3:0], 4'h0}; // RULE_03
        end
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            phase <= 2'h0;
            cr_turn <= 1'b0;
            cb_r <= 8'h00;
            cr_r <= 8'h00;
            pixel_out <= '0;
            pixel_valid_out <= 1'b0;
        end else if (ce_in) begin
            pixel_valid_out <= cap8 || cap16;
            if (!take) begin
                phase <= 2'h0; // RULE_06
                cr_turn <= 1'b0;
            end else begin
                phase <= phase + 2'h1;
                if (!wide && phase == VEPIX_PH_CB) cb_r <= lo; // RULE_11
                if (!wide && phase == VEPIX_PH_CR) cr_r <= lo; // RULE_11
                if (cap16) begin
                    cr_turn <= ~cr_turn;
                    if (cr_turn) cr_r <= hi;
                    else cb_r <= hi;
                end
            end
            if (cap8 || cap16) pixel_out <= next_pix;
        end
    end

    // Serial control port: answers its own address with an acknowledge
    vepix_ser_e ser_st, next_ser_st;
    logic scl_d, sda_d;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    wire scl_rise = !scl_d && scl_s; // RULE_10
    wire scl_fall = scl_d && !scl_s;
    wire ser_start = scl_s && sda_d && !sda_s;
    wire ser_stop = scl_s && !sda_d && sda_s;
    wire addr_ok = shreg[7:1] == {VEPIX_SER_ADDR_HI, addr_sel_s}; // RULE_07
    always_comb begin
        next_ser_st = ser_st;
        case (ser_st)
            VEPIX_SER_IDLE: next_ser_st = ser_st;
            VEPIX_SER_ADDR: begin
                if (scl_fall && bit_cnt == 4'h8) begin
                    next_ser_st = addr_ok ? VEPIX_SER_ACK : VEPIX_SER_IDLE;
                end
            end
            VEPIX_SER_ACK: if (scl_fall) next_ser_st = VEPIX_SER_DONE;
            VEPIX_SER_DONE: next_ser_st = ser_st;
            default: next_ser_st = VEPIX_SER_IDLE;
        endcase
        if (ser_start) next_ser_st = VEPIX_SER_ADDR;
        else if (ser_stop) next_ser_st = VEPIX_SER_IDLE;
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ser_st <= VEPIX_SER_IDLE;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ser_hit <= 1'b0;
        end else if (ce_in) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            ser_st <= next_ser_st;
            if (ser_start) bit_cnt <= 4'h0;
            else if (scl_rise && ser_st == VEPIX_SER_ADDR) begin
                bit_cnt <= bit_cnt + 4'h1;
                shreg <= {shreg[6:0], sda_s};
            end
            if (next_ser_st == VEPIX_SER_ACK) ser_hit <= 1'b1;
        end
    end
    assign control_serial_data_out = 1'b0;
    assign control_serial_data_oe_n_out = ser_st != VEPIX_SER_ACK; // RULE_10

    // Checks
    default clocking cb_chk @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_wide_take;
        ce_in && cap16;
    endsequence
    sequence s_quiet_next;
        ce_in ##1 !pixel_valid_out;
    endsequence
    a_blank_ignores: assert property ( // RULE_06
        ce_in && !blank_s |=> !pixel_valid_out)
        else $error("pixel accepted while blanking low");
    a_wide_every_second: assert property ( // RULE_12
        s_wide_take |=> s_quiet_next)
        else $error("16-bit capture on consecutive edges");
    a_reset_defaults: assert property ( // RULE_08
        $past(sys_rst_in) |-> !master && tmode == 2'h0 && !wide && !std_pal)
        else $error("reset defaults not loaded");
    a_hsync_line_start: assert property ( // RULE_04
        ce_in && master && line_end |=> !hsync_out)
        else $error("hsync not active at line start");
    a_slave_line_align: assert property ( // RULE_13
        ce_in && !master && hs_fall |=> h_cnt == 12'h000)
        else $error("line counter not aligned to received sync");
    a_field_pin_mode: assert property ( // RULE_05
        master && tmode != VEPIX_TMODE_VSYNC |-> field_vsync_out == field)
        else $error("field pin does not carry field flag");
    a_overlay_subst: assert property ( // RULE_03
        ce_in && ovl_s && (cap8 || cap16) |=>
        pixel_out.y[7:4] == $past(ovl_col[11:8]))
        else $error("overlay colour not substituted");
    a_ack_addr_match: assert property ( // RULE_07
        !control_serial_data_oe_n_out |-> ser_hit && addr_ok)
        else $error("acknowledge without address match");
    a_clkdiv_half: assert property ( // RULE_01
        ce_in ##1 ce_in |-> div_ff != $past(div_ff))
        else $error("divided clock did not toggle");
endmodule : vepix_port

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the pixel timing port.
// Assumes: Small line and field sizes keep timing checks short.
// Notes: Serial data is open drain with a pull-up.
`timescale 1ns/1ps
module testbench;
    import vepix_pkg::*;
    localparam int LC = 32;
    localparam int FL = 8;
    localparam int HC = 4;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] r;
    } vepix_row_s;
    vepix_row_s rows [5] = '{'{8'h00, 32'h5, 32'h5}, '{8'h04, 32'h6, 32'h6},
        '{8'h08, 32'hD, 32'hD}, '{8'h20, 32'hFFFFFFFF, 32'h0},
        '{8'h5C, 32'hFFF, 32'hFFF}};
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic send = 1'b0;
    logic wide = 1'b0;
    logic [31:0] word = 32'h0;
    logic hs_req = 1'b0;
    logic fld_req = 1'b0;
    logic ovl_en = 1'b0;
    logic [2:0] ovl_sel = 3'h0;
    logic addr_sel = 1'b0;
    logic scl = 1'b1;
    logic sda = 1'b1;
    logic [15:0] m_bus;
    logic m_blank, m_hs, m_fld, f, a;
    int bad_count = 0;
    int samples_checked = 0;
    int n;
    vepix_ahb_req_s ahb_req;
    logic [31:0] hrdata_out;
    logic hreadyout_out, hresp_out, hsync_out, hsync_oe_n_out;
    logic field_vsync_out, field_vsync_oe_n_out, pixel_valid_out;
    logic control_serial_data_out, control_serial_data_oe_n_out;
    logic clock_div_out;
    vepix_pixel_s pixel_out;
    vepix_pixel_s pq [$];
    wire logic hs_pin = hsync_oe_n_out ? m_hs : hsync_out;
    wire logic fv_pin = field_vsync_oe_n_out ? m_fld : field_vsync_out;
    wire logic sda_pin = sda & (control_serial_data_oe_n_out |
        control_serial_data_out);
    assign ahb_req = '{hsel, {24'h0, haddr}, htrans, hwrite,
        VEPIX_HSIZE_WORD, hreadyout_out};
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    vepix_decoder_model i_vepix_decoder_model (.clk_in(clk_in),
        .send_in(send), .wide_in(wide), .word_in(word),
        .hsync_req_in(hs_req), .field_req_in(fld_req),
        .pixel_bus_out(m_bus), .blank_out(m_blank), .hsync_out(m_hs),
        .field_out(m_fld));
    vepix_port #(.LINE_CLKS(LC), .FIELD_LINES(FL), .HSYNC_CLKS(HC),
        .VSYNC_LINES(2)) i_vepix_port (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .ce_in(1'b1), .ahb_req_in(ahb_req),
        .hwdata_in(hwdata), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .pixel_bus_in(m_bus), .blank_in(m_blank), .hsync_in(hs_pin),
        .hsync_out(hsync_out), .hsync_oe_n_out(hsync_oe_n_out),
        .field_vsync_in(fv_pin), .field_vsync_out(field_vsync_out),
        .field_vsync_oe_n_out(field_vsync_oe_n_out),
        .overlay_enable_in(ovl_en), .overlay_color_select_in(ovl_sel),
        .address_select_pin_in(addr_sel), .control_serial_clock_in(scl),
        .control_serial_data_in(sda_pin),
        .control_serial_data_out(control_serial_data_out),
        .control_serial_data_oe_n_out(control_serial_data_oe_n_out),
        .pixel_out(pixel_out), .pixel_valid_out(pixel_valid_out),
        .clock_div_out(clock_div_out));
    always @(posedge clk_in) begin
        if (pixel_valid_out === 1'b1) begin
            pq.push_back(pixel_out);
        end
    end
    task automatic finish_test;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
        input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
    endtask : tick
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1) begin
            k++;
            if (k > 100) begin
                chk(0, 1, "bus hang");
                finish_test();
            end
            @(posedge clk_in);
        end
    endtask : wait_rdy
    task automatic ahb(input logic w, input logic [7:0] ad,
        input logic [31:0] wd);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= ad;
        htrans <= VEPIX_HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata_out;
        chk(hresp_out, 0, "bus response");
    endtask : ahb
    task automatic px(input logic [31:0] w);
        pq.delete();
        @(posedge clk_in);
        word <= w;
        send <= 1'b1;
        @(posedge clk_in);
        send <= 1'b0;
        tick(12);
    endtask : px
    task automatic sbit(input logic v);
        sda <= v;
        tick(8);
        scl <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(8);
    endtask : sbit
    task automatic ser_addr(input logic [7:0] b, input logic ack);
        sda <= 1'b0;
        tick(8);
        scl <= 1'b0;
        tick(8);
        for (int i = 7; i >= 0; i--) begin
            sbit(b[i]);
        end
        sda <= 1'b1;
        tick(2);
        chk(control_serial_data_oe_n_out, !ack, "serial ack");
        sbit(1'b1);
        sda <= 1'b0;
        tick(8);
        scl <= 1'b1;
        tick(8);
        sda <= 1'b1;
        tick(8);
    endtask : ser_addr
    initial begin
        tick(2);
        sys_rst_in <= 1'b0;
        tick(1);
        chk({hsync_oe_n_out, field_vsync_oe_n_out, clock_div_out,
            pixel_valid_out}, 4'hC, "reset pins");
        for (int i = 0; i < 3; i++) begin
            ahb(0, 8'(4 * i), 0);
            chk(rd, 0, "reset mode");
        end
        foreach (rows[i]) begin
            ahb(1, rows[i].a, rows[i].w);
            ahb(0, rows[i].a, 0);
            chk(rd, rows[i].r, "register");
        end
        ahb(1, VEPIX_TIMING_ADDR, 0);
        ahb(1, VEPIX_MODE3_ADDR, 0);
        px(32'h0);
        pq.delete();
        tick(20);
        chk(pq.size(), 0, "blank low");
        px(32'h11223344);
        chk(pq.size(), 2, "8-bit count");
        chk({pq[0][23:8], pq[1]}, 40'h2211441133, "8-bit");
        ahb(1, VEPIX_MODE3_ADDR, 32'h1);
        wide <= 1'b1;
        px(32'hA1B2C3D4);
        chk(pq.size(), 2, "16-bit count");
        chk(pq[1], 24'hD4A1C3, "16-bit");
        ahb(1, VEPIX_MODE3_ADDR, 32'h0);
        wide <= 1'b0;
        ovl_en <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            ahb(1, VEPIX_OVL_BASE + 8'(4 * i),
                32'(i * 256 + (15 - i) * 16 + i + 1));
            ovl_sel <= 3'(i);
            px(32'h11223344);
            chk(pq[1], {4'(i), 4'h0, 4'(15 - i), 4'h0, 4'(i + 1), 4'h0},
                "overlay");
        end
        ovl_en <= 1'b0;
        addr_sel <= 1'b1;
        tick(4);
        ahb(0, VEPIX_STATUS_ADDR, 0);
        chk(rd[18:17], 2'h1, "address pin");
        ser_addr({VEPIX_SER_ADDR_HI, 2'b00}, 1'b0);
        ser_addr({VEPIX_SER_ADDR_HI, 2'b10}, 1'b1);
        ahb(0, VEPIX_STATUS_ADDR, 0);
        chk(rd[18], 1, "serial match");
        ahb(1, VEPIX_MODE3_ADDR, 32'hC);
        @(posedge clk_in);
        #1 a = clock_div_out;
        @(posedge clk_in);
        #1 chk(a ^ clock_div_out, 1, "half rate");
        ahb(1, VEPIX_MODE3_ADDR, 32'h8);
        #1 chk(clock_div_out, 1, "full rate high");
        #5 chk(clock_div_out, 0, "full rate low");
        ahb(1, VEPIX_MODE3_ADDR, 32'h0);
        // Slave mode 0: a field pin change zeroes the line count
        fld_req <= 1'b1;
        tick(6);
        repeat (3) begin
            hs_req <= 1'b1;
            tick(2);
            hs_req <= 1'b0;
            tick(LC);
        end
        ahb(0, VEPIX_STATUS_ADDR, 0);
        chk(rd[16:0], 17'h10003, "line count runs");
        fld_req <= 1'b0;
        tick(6);
        ahb(0, VEPIX_STATUS_ADDR, 0);
        chk(rd[16:0], 17'h00000, "slave align");
        ahb(1, VEPIX_TIMING_ADDR, 32'h5);
        tick(6);
        chk({hsync_oe_n_out, field_vsync_oe_n_out}, 0, "master");
        n = 0;
        repeat (2 * LC) begin
            @(posedge clk_in);
            n += int'(hsync_out === 1'b0);
        end
        chk(n, 2 * HC, "hsync width");
        n = 0;
        repeat (LC * FL) begin
            @(posedge clk_in);
            n += int'(field_vsync_out === 1'b0);
        end
        chk(n, 2 * LC, "vsync width");
        ahb(1, VEPIX_TIMING_ADDR, 32'h3);
        tick(4);
        f = field_vsync_out;
        tick(LC * FL);
        chk(field_vsync_out, !f, "field flag");
        sys_rst_in <= 1'b1;
        tick(2);
        sys_rst_in <= 1'b0;
        chk(hsync_oe_n_out, 1, "second reset");
        ahb(0, VEPIX_TIMING_ADDR, 0);
        chk(rd, 0, "second reset mode");
        finish_test();
    end
    initial begin
        tick(100000);
        chk(0, 1, "timeout");
        finish_test();
    end
endmodule : testbench

// *** verification/vepix_decoder_model.sv ***
// Purpose: Decoder-side model driving pixel bytes, blanking and syncs.
// Assumes: Bus changes just after the rising clock edge.
// Notes: An idle bus inverts every bit each clock, alternating its last value and its inverse.
`timescale 1ns/1ps
module vepix_decoder_model (
    // Clock and commands
    input wire logic clk_in,
    input wire logic send_in,
    input wire logic wide_in,
    input wire logic [31:0] word_in,
    input wire logic hsync_req_in,
    input wire logic field_req_in,
    // Pins towards the encoder
    output logic [15:0] pixel_bus_out,
    output logic blank_out,
    output logic hsync_out,
    output logic field_out
);
    logic [2:0] step = 3'h0;
    logic [31:0] word = 32'h0;
    logic [7:0] lane;
    initial pixel_bus_out = 16'h0;
    initial blank_out = 1'b0;
    // Word holds Cb, Y, Cr, Y from the top byte down
    assign lane = 8'(word >> {step - 3'h1, 3'h0});
    assign hsync_out = ~hsync_req_in;
    assign field_out = field_req_in;
    always @(posedge clk_in) begin
        if (send_in) begin
            word <= word_in;
            step <= 3'h4;
        end else if (step != 3'h0) begin
            step <= step - 3'h1;
        end
        if (step != 3'h0) begin
            blank_out <= 1'b1;
            // Wide words stand two edges each: {Cb,Y} then {Cr,Y}
            pixel_bus_out <= wide_in ? (step > 3'h2 ? word[31:16] :
                word[15:0]) : {~lane, lane};
        end else begin
            blank_out <= 1'b0;
            pixel_bus_out <= ~pixel_bus_out;
        end
    end
endmodule : vepix_decoder_model
